//--- hdl/pif_flag_cell.sv
// one software-cleared interrupt flag with set priority
`timescale 1ns/1ps
`default_nettype none
module pif_flag_cell (
	input  wire logic i_ref_clk,
	input  wire logic i_nrst,
	input  wire logic i_set,
	input  wire logic i_wr,
	input  wire logic i_wdata,
	output var  logic o_flag
);
	import pif_pkg::*;

	// ==========================================================================
	// flag storage
	// a set in the cycle of a clearing write still lands
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			o_flag <= 1'b0;
		end else if (i_set) begin
			o_flag <= 1'b1;
		end else if (i_wr) begin
			o_flag <= i_wdata;
		end
	end

endmodule : pif_flag_cell
`default_nettype wire

//--- hdl/pif_flags.sv
// peripheral interrupt flag banks with an axi4-lite register slave
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module pif_flags (
	input  wire logic                           i_ref_clk,
	input  wire logic                           i_nrst,
	// axi4-lite slave
	input  wire logic [pif_pkg::PIF_ADDR_W-1:0] i_awaddr,
	input  wire logic                           i_awvalid,
	output var  logic                           o_awready,
	input  wire logic [pif_pkg::PIF_DATA_W-1:0] i_wdata,
	input  wire logic [3:0]                     i_wstrb,
	input  wire logic                           i_wvalid,
	output var  logic                           o_wready,
	output var  logic [1:0]                     o_bresp,
	output var  logic                           o_bvalid,
	input  wire logic                           i_bready,
	input  wire logic [pif_pkg::PIF_ADDR_W-1:0] i_araddr,
	input  wire logic                           i_arvalid,
	output var  logic                           o_arready,
	output var  logic [pif_pkg::PIF_DATA_W-1:0] o_rdata,
	output var  logic [1:0]                     o_rresp,
	output var  logic                           o_rvalid,
	input  wire logic                           i_rready,
	// peripheral side
	input  wire pif_pkg::pif_events_t           i_events,
	input  wire pif_pkg::pif_uart_t             i_uart,
	input  wire logic [1:0]                     i_cmp_out,
	input  wire logic                           i_voltage_above,
	// processor side
	output var  logic                           o_periph_irq
);
	import pif_pkg::*;

	// ==========================================================================
	// state
	logic [PIF_NUM_BITS-1:0] flags;
	logic [PIF_NUM_BITS-1:0] enables;
	logic [PIF_BANK_W-1:0]   ctrl;
	logic [PIF_NUM_BITS-1:0] hw_set;
	logic [PIF_NUM_BITS-1:0] auto_level;
	logic [PIF_NUM_BITS-1:0] auto_clr;

	// ==========================================================================
	// asynchronous analog levels: two flops, then an edge stage
	logic [2:0] async_s1;
	logic [2:0] async_s2;
	logic [2:0] async_s3;
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			async_s1 <= 3'h0;
			async_s2 <= 3'h0;
			async_s3 <= 3'h0;
		end else begin
			async_s1 <= {i_voltage_above, i_cmp_out};
			async_s2 <= async_s1;
			async_s3 <= async_s2;
		end
	end

	// a pin already high at release must not look like a change: edges count
	// only once the edge stage holds a synchronised sample
	logic [1:0] sync_fill;
	wire        sync_primed = &sync_fill;
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			sync_fill <= 2'h0;
		end else if (!sync_primed) begin
			sync_fill <= sync_fill + 2'h1;
		end
	end

	wire [1:0] cmp_change = (async_s2[1:0] ^ async_s3[1:0]) & {2{sync_primed}};
	wire       vdir_rise  = ctrl[PIF_CTRL_VDIR];
	wire       lv_rise    = async_s2[2] & ~async_s3[2];
	wire       lv_fall    = ~async_s2[2] & async_s3[2];
	wire       lv_event   = sync_primed & (vdir_rise ? lv_rise : lv_fall);
	// pwm mode suppresses the capture/compare event
	wire [4:0] capcomp_hit = i_events.capcomp_evt & ~i_events.capcomp_pwm;

	// ==========================================================================
	// set sources, no enable takes part here
	always_comb begin
		hw_set                      = '0;
		hw_set[PIF_B_CONV_DONE]     = i_events.conv_done;
		hw_set[PIF_B_SYNC_A_DONE]   = i_events.sync_a_done;
		hw_set[PIF_B_CAPCOMP_A]     = capcomp_hit[0];
		hw_set[PIF_B_TIMER_B_MATCH] = i_events.timer_b_match;
		hw_set[PIF_B_TIMER_A_OVF]   = i_events.timer_a_ovf;
		hw_set[PIF_B_CLOCK_FAIL]    = i_events.clock_fail;
		hw_set[PIF_B_CMP_A]         = cmp_change[0];
		hw_set[PIF_B_CMP_B]         = cmp_change[1];
		hw_set[PIF_B_NV_WRITE]      = i_events.nv_write_done;
		hw_set[PIF_B_SYNC_A_COLL]   = i_events.sync_a_collision;
		hw_set[PIF_B_LOW_VOLTAGE]   = lv_event;
		hw_set[PIF_B_TIMER_C_OVF]   = i_events.timer_c_ovf;
		hw_set[PIF_B_CAPCOMP_B]     = capcomp_hit[1];
		hw_set[PIF_B_SYNC_B_DONE]   = i_events.sync_b_done;
		hw_set[PIF_B_SYNC_B_COLL]   = i_events.sync_b_collision;
		hw_set[PIF_B_CHARGE_TIMER]  = i_events.charge_timer;
		hw_set[PIF_B_GATE_E]        = i_events.timer_gate[2];
		hw_set[PIF_B_GATE_C]        = i_events.timer_gate[1];
		hw_set[PIF_B_GATE_A]        = i_events.timer_gate[0];
		hw_set[PIF_B_CAPCOMP_E]     = capcomp_hit[4];
		hw_set[PIF_B_CAPCOMP_D]     = capcomp_hit[3];
		hw_set[PIF_B_CAPCOMP_C]     = capcomp_hit[2];
		hw_set[PIF_B_TIMER_F_MATCH] = i_events.timer_f_match;
		hw_set[PIF_B_TIMER_E_OVF]   = i_events.timer_e_ovf;
		hw_set[PIF_B_TIMER_D_MATCH] = i_events.timer_d_match;
	end

	always_comb begin
		auto_level                  = '0;
		auto_clr                    = '0;
		auto_level[PIF_B_UART_A_RX] = i_uart.rx_full[0];
		auto_clr[PIF_B_UART_A_RX]   = i_uart.rx_read[0];
		auto_level[PIF_B_UART_A_TX] = i_uart.tx_empty[0];
		auto_clr[PIF_B_UART_A_TX]   = i_uart.tx_write[0];
		auto_level[PIF_B_UART_B_RX] = i_uart.rx_full[1];
		auto_clr[PIF_B_UART_B_RX]   = i_uart.rx_read[1];
		auto_level[PIF_B_UART_B_TX] = i_uart.tx_empty[1];
		auto_clr[PIF_B_UART_B_TX]   = i_uart.tx_write[1];
	end

	// ==========================================================================
	// axi4-lite write channel: address and data taken in either order
	logic                  aw_held;
	logic                  w_held;
	logic [5:0]            aw_word;
	logic [PIF_BANK_W-1:0] w_byte;
	logic                  w_lane0;

	wire       aw_take  = i_awvalid & o_awready;
	wire       w_take   = i_wvalid & o_wready;
	wire       do_write = aw_held & w_held & ~o_bvalid;
	wire       wr_en    = do_write & w_lane0;
	wire       wr_map   = aw_word <= PIF_IDX_CTRL;
	wire [5:0] wr_enidx = aw_word - PIF_IDX_ENABLE_FIRST;

	assign o_awready = ~aw_held;
	assign o_wready  = ~w_held;

	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_word <= 6'h00;
			w_byte  <= 8'h00;
			w_lane0 <= 1'b0;
			o_bvalid <= 1'b0;
			o_bresp <= PIF_RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_held <= 1'b1;
				aw_word <= i_awaddr[PIF_ADDR_W-1:2];
			end else if (do_write) begin
				aw_held <= 1'b0;
			end
			if (w_take) begin
				w_held  <= 1'b1;
				w_byte  <= i_wdata[PIF_BANK_W-1:0];
				w_lane0 <= i_wstrb[0];
			end else if (do_write) begin
				w_held <= 1'b0;
			end
			if (do_write) begin
				o_bvalid <= 1'b1;
				o_bresp  <= wr_map ? PIF_RESP_OKAY : PIF_RESP_SLVERR;
			end else if (i_bready) begin
				o_bvalid <= 1'b0;
			end
		end
	end

	// ==========================================================================
	// flag banks, one cell or one tracking flop per implemented bit, unimplemented bits tied to zero
	genvar gi;
	generate
		for (gi = 0; gi < PIF_NUM_BITS; gi++) begin : g_bit
			localparam logic [5:0] BANK = 6'(gi / PIF_BANK_W);
			localparam int         POS  = gi % PIF_BANK_W;
			wire flag_wr = wr_en & (aw_word == PIF_IDX_FLAG_FIRST + BANK);
			wire en_wr   = wr_en & (wr_enidx == BANK) & (aw_word >= PIF_IDX_ENABLE_FIRST);
			if (!PIF_IMPL_MASK[gi]) begin : g_none
				assign flags[gi]   = 1'b0;
				assign enables[gi] = 1'b0;
			end else begin : g_impl
				if (PIF_AUTO_MASK[gi]) begin : g_auto
					// read-only: the serial port owns the buffer state
					always_ff @(posedge i_ref_clk) begin
						if (!i_nrst) begin
							flags[gi] <= PIF_FLAG_RESET[gi];
						end else begin
							flags[gi] <= auto_level[gi] & ~auto_clr[gi];
						end
					end
				end else begin : g_sticky
					pif_flag_cell u_cell (
						.i_ref_clk (i_ref_clk),
						.i_nrst    (i_nrst),
						.i_set     (hw_set[gi]),
						.i_wr      (flag_wr),
						.i_wdata   (w_byte[POS]),
						.o_flag    (flags[gi])
					);
				end
				always_ff @(posedge i_ref_clk) begin
					if (!i_nrst) begin
						enables[gi] <= PIF_ENABLE_RESET[gi];
					end else if (en_wr) begin
						enables[gi] <= w_byte[POS];
					end
				end
			end
		end
	endgenerate

	wire ctrl_wr = wr_en & (aw_word == PIF_IDX_CTRL);
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			ctrl <= PIF_CTRL_RESET;
		end else if (ctrl_wr) begin
			ctrl <= w_byte & PIF_CTRL_MASK;
		end
	end

	// ==========================================================================
	// request to the processor
	// with priority mode on, gating by level belongs to the priority logic outside
	wire periph_gate = ctrl[PIF_CTRL_PRIO_MODE] | ctrl[PIF_CTRL_PERIPH_EN];
	wire next_irq    = (|(flags & enables)) & periph_gate;
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			o_periph_irq <= 1'b0;
		end else begin
			o_periph_irq <= next_irq;
		end
	end

	// ==========================================================================
	// axi4-lite read channel
	wire [5:0]            ar_word  = i_araddr[PIF_ADDR_W-1:2];
	wire [5:0]            ar_enidx = ar_word - PIF_IDX_ENABLE_FIRST;
	wire                  ar_flag  = ar_word < PIF_IDX_ENABLE_FIRST;
	wire                  ar_en    = (ar_word >= PIF_IDX_ENABLE_FIRST) & (ar_word < PIF_IDX_CTRL);
	wire                  ar_ctrl  = ar_word == PIF_IDX_CTRL;
	wire [PIF_BANK_W-1:0] rd_flag  = flags[{ar_word[2:0], 3'h0} +: PIF_BANK_W];
	wire [PIF_BANK_W-1:0] rd_en    = enables[{ar_enidx[2:0], 3'h0} +: PIF_BANK_W];
	wire [PIF_BANK_W-1:0] rd_byte  = ar_flag ? rd_flag :
	                                 ar_en   ? rd_en   :
	                                 ar_ctrl ? ctrl    : 8'h00;
	wire                  ar_take  = i_arvalid & o_arready;

	assign o_arready = ~o_rvalid;

	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			o_rvalid <= 1'b0;
			o_rdata  <= 32'h0000_0000;
			o_rresp  <= PIF_RESP_OKAY;
		end else if (ar_take) begin
			o_rvalid <= 1'b1;
			o_rdata  <= {24'h00_0000, rd_byte};
			o_rresp  <= (ar_flag | ar_en | ar_ctrl) ? PIF_RESP_OKAY : PIF_RESP_SLVERR;
		end else if (i_rready) begin
			o_rvalid <= 1'b0;
		end
	end

	// ==========================================================================
	// checks
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_nrst);

	wire bank1_wr = wr_en & (aw_word == PIF_IDX_FLAG_FIRST);

	chk_unimpl_zero: assert property ((flags & ~PIF_IMPL_MASK) == '0)
		else $error("unimplemented flag bit reads one");
	chk_conv_sticky: assert property (i_events.conv_done
		|=> flags[PIF_B_CONV_DONE] ##1 (flags[PIF_B_CONV_DONE] || $past(bank1_wr)))
		else $error("conversion flag not held after event");
	chk_rx_read_clears: assert property (i_uart.rx_read[0] |=> !flags[PIF_B_UART_A_RX])
		else $error("receive flag survived buffer read");
	chk_tx_write_clears: assert property (i_uart.tx_write[0] ##0 !i_uart.tx_empty[0]
		|=> !flags[PIF_B_UART_A_TX] [*2])
		else $error("transmit flag high after buffer write");
	chk_pwm_ignored: assert property (i_events.capcomp_pwm[0] && !bank1_wr
		&& !flags[PIF_B_CAPCOMP_A] |=> !flags[PIF_B_CAPCOMP_A])
		else $error("capture flag set in pwm mode");
	chk_set_over_clear: assert property (i_events.timer_a_ovf && bank1_wr
		&& !w_byte[PIF_B_TIMER_A_OVF] |=> flags[PIF_B_TIMER_A_OVF])
		else $error("clearing write lost a timer event");
	chk_fail_holds: assert property (flags[PIF_B_CLOCK_FAIL]
		&& !(wr_en && aw_word == PIF_IDX_FLAG_FIRST + 6'h01) |=> flags[PIF_B_CLOCK_FAIL])
		else $error("clock fail flag dropped without software");
	chk_gate_sticky: assert property (flags[PIF_B_GATE_A]
		&& !(wr_en && aw_word == PIF_IDX_FLAG_FIRST + 6'h02) |=> flags[PIF_B_GATE_A])
		else $error("timer gate flag dropped without software");
	chk_lv_direction: assert property ($rose(async_s2[2]) && !vdir_rise
		&& !flags[PIF_B_LOW_VOLTAGE] && !wr_en |=> !flags[PIF_B_LOW_VOLTAGE])
		else $error("low voltage flag set on wrong direction");
	chk_enable_free: assert property (i_events.timer_f_match && enables == '0
		|=> flags[PIF_B_TIMER_F_MATCH])
		else $error("flag needed an enable to set");
	chk_irq_gated: assert property (!ctrl[PIF_CTRL_PRIO_MODE]
		&& !ctrl[PIF_CTRL_PERIPH_EN] |=> !o_periph_irq)
		else $error("request passed with peripheral enable low");
	chk_irq_raise: assert property ((flags & enables) != '0 && periph_gate
		|=> o_periph_irq)
		else $error("enabled flag gave no request");
	chk_cmp_change: assert property (sync_primed && $changed(async_s2[0])
		|=> flags[PIF_B_CMP_A])
		else $error("comparator change not flagged");

	cov_write_flag:  cover property (bank1_wr ##1 o_bvalid);
	cov_irq_rise:    cover property (!o_periph_irq ##1 o_periph_irq);
	cov_set_collide: cover property (i_events.timer_a_ovf && bank1_wr);
	cov_unmapped_rd: cover property (o_rvalid && o_rresp == PIF_RESP_SLVERR);

endmodule : pif_flags
`default_nettype wire

//--- hdl/pif_pkg.sv
// shared constants and carrier types for the peripheral interrupt flag banks
package pif_pkg;

	// ==========================================================================
	// bus geometry
	localparam int        PIF_ADDR_W        = 8;
	localparam int        PIF_DATA_W        = 32;
	localparam int        PIF_BANK_W        = 8;
	localparam int        PIF_NUM_BANKS     = 5;
	localparam int        PIF_NUM_BITS      = PIF_NUM_BANKS * PIF_BANK_W;
	localparam logic [1:0] PIF_RESP_OKAY    = 2'h0;
	localparam logic [1:0] PIF_RESP_SLVERR  = 2'h2;

	// ==========================================================================
	// register word indexes, byte address = index * 4
	localparam logic [5:0] PIF_IDX_FLAG_FIRST   = 6'h00;
	localparam logic [5:0] PIF_IDX_ENABLE_FIRST = 6'h05;
	localparam logic [5:0] PIF_IDX_CTRL         = 6'h0A;

	// ==========================================================================
	// control register fields and reset values
	localparam int        PIF_CTRL_PERIPH_EN  = 0;
	localparam int        PIF_CTRL_PRIO_MODE  = 1;
	localparam int        PIF_CTRL_VDIR       = 2;
	localparam logic [7:0] PIF_CTRL_MASK      = 8'h07;
	localparam logic [7:0] PIF_CTRL_RESET     = 8'h00;
	localparam logic [39:0] PIF_ENABLE_RESET  = 40'h00_0000_0000;
	localparam logic [39:0] PIF_FLAG_RESET    = 40'h00_0000_0000;

	// implemented flag bits, bank one in the low byte
	localparam logic [39:0] PIF_IMPL_MASK = 40'h07_07FF_FF7F;
	// buffer-state flags follow the serial ports and ignore writes
	localparam logic [39:0] PIF_AUTO_MASK = 40'h00_0030_0030;

	// ==========================================================================
	// flag positions in the 40-bit flag vector (bank * 8 + bit)
	localparam int PIF_B_CONV_DONE     = 6;
	localparam int PIF_B_UART_A_RX     = 5;
	localparam int PIF_B_UART_A_TX     = 4;
	localparam int PIF_B_SYNC_A_DONE   = 3;
	localparam int PIF_B_CAPCOMP_A     = 2;
	localparam int PIF_B_TIMER_B_MATCH = 1;
	localparam int PIF_B_TIMER_A_OVF   = 0;
	localparam int PIF_B_CLOCK_FAIL    = 15;
	localparam int PIF_B_CMP_A         = 14;
	localparam int PIF_B_CMP_B         = 13;
	localparam int PIF_B_NV_WRITE      = 12;
	localparam int PIF_B_SYNC_A_COLL   = 11;
	localparam int PIF_B_LOW_VOLTAGE   = 10;
	localparam int PIF_B_TIMER_C_OVF   = 9;
	localparam int PIF_B_CAPCOMP_B     = 8;
	localparam int PIF_B_SYNC_B_DONE   = 23;
	localparam int PIF_B_SYNC_B_COLL   = 22;
	localparam int PIF_B_UART_B_RX     = 21;
	localparam int PIF_B_UART_B_TX     = 20;
	localparam int PIF_B_CHARGE_TIMER  = 19;
	localparam int PIF_B_GATE_E        = 18;
	localparam int PIF_B_GATE_C        = 17;
	localparam int PIF_B_GATE_A        = 16;
	localparam int PIF_B_CAPCOMP_E     = 26;
	localparam int PIF_B_CAPCOMP_D     = 25;
	localparam int PIF_B_CAPCOMP_C     = 24;
	localparam int PIF_B_TIMER_F_MATCH = 34;
	localparam int PIF_B_TIMER_E_OVF   = 33;
	localparam int PIF_B_TIMER_D_MATCH = 32;

	// ==========================================================================
	// carriers
	// one-cycle event pulses, plus the capcomp_pwm mode levels, from peripherals on the same clock
	typedef struct packed {
		logic       conv_done;
		logic       sync_a_done;
		logic       sync_a_collision;
		logic       sync_b_done;
		logic       sync_b_collision;
		logic [4:0] capcomp_evt;   // a..e in bits 0..4
		logic [4:0] capcomp_pwm;   // level: unit a..e in pwm mode
		logic       timer_a_ovf;
		logic       timer_b_match;
		logic       timer_c_ovf;
		logic       timer_d_match;
		logic       timer_e_ovf;
		logic       timer_f_match;
		logic [2:0] timer_gate;    // a, c, e in bits 0..2
		logic       clock_fail;
		logic       nv_write_done;
		logic       charge_timer;
	} pif_events_t;

	// serial buffer state, index 0 is port a, index 1 is port b
	typedef struct packed {
		logic [1:0] rx_full;
		logic [1:0] tx_empty;
		logic [1:0] rx_read;
		logic [1:0] tx_write;
	} pif_uart_t;

endpackage : pif_pkg

//--- test/pif_flags_tb.sv
// self-checking bench for the peripheral interrupt flag banks
`timescale 1ns/1ps
`default_nettype none
module pif_flags_tb;
	import pif_pkg::*;
	localparam logic [7:0] CTRL = {PIF_IDX_CTRL, 2'b00};
	logic        i_ref_clk = 1'b0;
	logic        i_nrst = 1'b0;
	logic [7:0]  i_awaddr = '0;
	logic [7:0]  i_araddr = '0;
	logic [31:0] i_wdata = '0;
	logic [3:0]  i_wstrb = 4'hF;
	logic        i_awvalid = 1'b0;
	logic        i_wvalid = 1'b0;
	logic        i_bready = 1'b1;
	logic        i_arvalid = 1'b0;
	logic        i_rready = 1'b1;
	logic        i_voltage_above = 1'b0;
	logic [1:0]  i_cmp_out = '0;
	logic [1:0]  rx_in = '0;
	logic [1:0]  tx_out = '0;
	logic [1:0]  rx_take = '0;
	logic [1:0]  tx_put = '0;
	pif_events_t fire = '0;
	pif_events_t i_events;
	pif_uart_t   i_uart;
	logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_periph_irq;
	logic [1:0]  o_bresp, o_rresp;
	logic [31:0] o_rdata;
	logic [31:0] seed = 32'h46A1;
	int          failures = 0;
	int          n_tests = 0;

	pif_periph_model model_u (.i_ref_clk, .i_nrst, .i_fire(fire), .i_rx_in(rx_in),
		.i_tx_out(tx_out), .i_rd(rx_take), .i_wr(tx_put), .o_events(i_events), .o_uart(i_uart));
	pif_flags dut_u (.i_ref_clk, .i_nrst, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
		.i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready,
		.o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_events, .i_uart, .i_cmp_out,
		.i_voltage_above, .o_periph_irq);

	initial begin
		forever #20 i_ref_clk = ~i_ref_clk;
	end

	// ====================
	// helpers
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	function automatic logic [39:0] ev_map(input pif_events_t e);
		logic [39:0] m;
		logic [4:0]  c;
		m = '0;
		c = e.capcomp_evt & ~e.capcomp_pwm;
		{m[26:24], m[8], m[2]} = {c[4:2], c[1], c[0]};
		m[PIF_B_CONV_DONE] = e.conv_done;
		m[PIF_B_SYNC_A_DONE] = e.sync_a_done;
		m[PIF_B_TIMER_B_MATCH] = e.timer_b_match;
		m[PIF_B_TIMER_A_OVF] = e.timer_a_ovf;
		m[PIF_B_TIMER_C_OVF] = e.timer_c_ovf;
		m[PIF_B_CLOCK_FAIL] = e.clock_fail;
		m[PIF_B_NV_WRITE] = e.nv_write_done;
		m[PIF_B_SYNC_A_COLL] = e.sync_a_collision;
		m[PIF_B_SYNC_B_DONE] = e.sync_b_done;
		m[PIF_B_SYNC_B_COLL] = e.sync_b_collision;
		m[PIF_B_CHARGE_TIMER] = e.charge_timer;
		m[18:16] = e.timer_gate;
		m[34:32] = {e.timer_f_match, e.timer_e_ovf, e.timer_d_match};
		return m;
	endfunction : ev_map

	task automatic check(input logic [39:0] got, input logic [39:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : check

	task automatic wrap_up;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up

	task automatic guard(input int n);
		if (n > 60) begin
			failures++;
			wrap_up();
		end
	endtask : guard

	// ====================
	// axi4-lite master, each channel released on its own ready
	task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] r);
		int n;
		n = 0;
		i_awaddr <= a;
		i_wdata <= {24'h0, v};
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		do begin
			@(posedge i_ref_clk);
			if (o_awready && i_awvalid)
				i_awvalid <= 1'b0;
			if (o_wready && i_wvalid)
				i_wvalid <= 1'b0;
			n++;
			guard(n);
		end while (!o_bvalid);
		r = o_bresp;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		i_araddr <= a;
		i_arvalid <= 1'b1;
		do begin
			@(posedge i_ref_clk);
			if (o_arready && i_arvalid)
				i_arvalid <= 1'b0;
			n++;
			guard(n);
		end while (!o_rvalid);
		d = o_rdata;
		r = o_rresp;
	endtask : rd

	task automatic read_all(input int base, output logic [39:0] f);
		logic [31:0] d;
		logic [1:0]  r;
		for (int b = 0; b < 5; b++) begin
			rd(8'(base + b * 4), d, r);
			f[b * 8 +: 8] = d[7:0];
		end
	endtask : read_all

	task automatic zero_all;
		logic [1:0] r;
		for (int a = 0; a < 40; a += 4)
			wr(8'(a), 8'h00, r);
	endtask : zero_all

	task automatic tick(input int n);
		repeat (n) @(posedge i_ref_clk);
	endtask : tick

	// ====================
	// main sequence
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		logic [39:0] f;
		pif_events_t ev;
		tick(8);
		i_nrst <= 1'b1;
		tick(1);
		for (int a = 0; a <= 40; a += 4) begin
			rd(8'(a), d, r);
			check({r, d}, '0);
		end
		rd(8'h2C, d, r);
		check({r, d}, {PIF_RESP_SLVERR, 32'h0});
		wr(8'h2C, 8'hFF, r);
		check(r, PIF_RESP_SLVERR);
		for (int a = 0; a < 44; a += 4)
			wr(8'(a), 8'hFF, r);
		read_all(0, f);
		check(f, 40'h07_07CF_FF4F);
		read_all(20, f);
		check(f, 40'h07_07FF_FF7F);
		rd(CTRL, d, r);
		check(d, 32'h7);
		// a write with byte lane zero off must leave the register alone
		i_wstrb <= 4'hE;
		wr(CTRL, 8'h00, r);
		i_wstrb <= 4'hF;
		check(r, PIF_RESP_OKAY);
		rd(CTRL, d, r);
		check(d, 32'h7);
		zero_all();
		// random event mixes, enables all off; first two are corner cases
		for (int i = 0; i < 12; i++) begin
			d = xs();
			ev = d[$bits(pif_events_t)-1:0];
			if (i < 2)
				ev = '1;
			if (i == 1)
				ev.capcomp_pwm = '0;
			fire <= ev;
			tick(1);
			fire <= '0;
			tick(2);
			read_all(0, f);
			check(f, ev_map(ev));
			zero_all();
		end
		// set lands on the same edge as the clearing write
		ev = '0;
		ev.conv_done = 1'b1;
		ev.timer_a_ovf = 1'b1;
		fork
			wr(8'h00, 8'h00, r);
			begin
				fire <= ev;
				tick(1);
				fire <= '0;
			end
		join
		rd(8'h00, d, r);
		check(d[7:0], 8'h41);
		for (int k = 0; k < 4; k++) begin
			wr(8'h14, k == 2 ? 8'h00 : 8'h40, r);
			wr(CTRL, k == 3 ? 8'h02 : 8'(k > 0), r);
			tick(3);
			check(o_periph_irq, k == 1 || k == 3);
		end
		for (int p = 0; p < 2; p++) begin
			rx_in[p] <= 1'b1;
			tx_out[p] <= 1'b1;
			tick(1);
			rx_in[p] <= 1'b0;
			tx_out[p] <= 1'b0;
			wr(8'(p * 8), 8'h00, r);
			rd(8'(p * 8), d, r);
			check(d[7:0], 8'h30);
			rx_take[p] <= 1'b1;
			tick(1);
			rx_take[p] <= 1'b0;
			tick(3);
			rd(8'(p * 8), d, r);
			check(d[7:0], 8'h10);
			tx_put[p] <= 1'b1;
			tick(1);
			tx_put[p] <= 1'b0;
			tick(3);
			rd(8'(p * 8), d, r);
			check(d[7:0], 8'h00);
		end
		// comparator edges and both detect directions
		for (int i = 0; i < 4; i++) begin
			wr(CTRL, {5'h0, i > 1, 2'b00}, r);
			wr(8'h04, 8'h00, r);
			i_voltage_above <= ~i_voltage_above;
			i_cmp_out[i % 2] <= ~i_cmp_out[i % 2];
			tick(6);
			rd(8'h04, d, r);
			check(d[7:0], {1'b0, i % 2 == 0, i % 2 == 1, 2'b00, (i % 2 == 0) == (i > 1), 2'b00});
		end
		wrap_up();
	end
endmodule : pif_flags_tb
`default_nettype wire

//--- test/pif_periph_model.sv
// peripheral side model: event pulses and serial buffer levels
`timescale 1ns/1ps
`default_nettype none
module pif_periph_model (
	input  wire logic                 i_ref_clk,
	input  wire logic                 i_nrst,
	input  wire pif_pkg::pif_events_t i_fire,
	input  wire logic [1:0]           i_rx_in,
	input  wire logic [1:0]           i_tx_out,
	input  wire logic [1:0]           i_rd,
	input  wire logic [1:0]           i_wr,
	output var  pif_pkg::pif_events_t o_events,
	output var  pif_pkg::pif_uart_t   o_uart
);
	import pif_pkg::*;
	// ====================
	// buffers move only on command, so the bench owns every timing
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			o_events <= '0;
			o_uart   <= '0;
		end else begin
			o_events        <= i_fire;
			o_uart.rx_full  <= (o_uart.rx_full | i_rx_in) & ~i_rd;
			o_uart.tx_empty <= (o_uart.tx_empty | i_tx_out) & ~i_wr;
			o_uart.rx_read  <= i_rd;
			o_uart.tx_write <= i_wr;
		end
	end
endmodule : pif_periph_model
`default_nettype wire
